// [pkg/rcf_pkg.sv]
package rcf_pkg;
	// protocol data block word 0 layout
	localparam int OPT_SHIFT_BIT = 0;
	localparam int OPT_SNS_LO    = 1;
	localparam int LEAD_LO       = 24;
	// options size codes (encap bits 2:1)
	localparam logic [1:0] SNS_AM12  = 2'h0;
	localparam logic [1:0] SNS_UM7   = 2'h1;
	localparam logic [1:0] SNS_LEN15 = 2'h2;
	localparam logic [1:0] SNS_RSVD  = 2'h3;
	// override register layout
	localparam int OVR_FLAG_BIT = 31;
	localparam int HFN_W20      = 20;
	localparam int HFN_W25      = 25;
	localparam logic [31:0] OVR_RESET = 32'h0000_0000;
	// cipher selection
	localparam logic [1:0] ALG_NULL  = 2'h0;
	localparam logic [1:0] ALG_KASUMI = 2'h1;
	localparam logic [1:0] ALG_SNOW  = 2'h2;
	// completion status codes
	localparam logic [1:0] ST_OK     = 2'h0;
	localparam logic [1:0] ST_REKEY  = 2'h1;
	localparam logic [1:0] ST_BADOPT = 2'h2;
endpackage

// [hw/rcf_seq_track.sv]
`timescale 1ns/1ps
module rcf_seq_track
	import rcf_pkg::*;
#(
	parameter int HFN_W = 25
)(
	// header and state
	input  wire logic             um7_i,
	input  wire logic [15:0]      hdr_i,
	input  wire logic [HFN_W-1:0] hfn_i,
	input  wire logic [HFN_W-1:0] thresh_i,
	input  wire logic [11:0]      last_sn_i,
	input  wire logic             last_vld_i,
	// results
	output logic      [11:0]      sn_o,
	output logic                  wrap_o,
	output logic      [HFN_W-1:0] hfn_next_o,
	output logic                  rekey_o
);
	// am: sn in header bits 14:3 after d/c bit; um: sn in top seven bits
	always_comb
	begin
		sn_o = um7_i ? {5'h00, hdr_i[15:9]} : hdr_i[14:3];
		wrap_o = last_vld_i && (sn_o == 12'h000) &&
			(um7_i ? (last_sn_i[6:0] == 7'h7F) : (last_sn_i == 12'hFFF));
		// counter never moves backward; only a wrap bumps it
		hfn_next_o = wrap_o ? hfn_i + HFN_W'(1) : hfn_i;
		rekey_o = (hfn_next_o >= thresh_i);
	end
endmodule

// [hw/rcf_nibble_align.sv]
`timescale 1ns/1ps
module rcf_nibble_align
(
	// byte stream pair
	input  wire logic [7:0] cur_i,
	input  wire logic [3:0] carry_i,
	input  wire logic       enc_i,
	// realigned byte and new carry
	output logic      [7:0] byte_o,
	output logic      [3:0] carry_o
);
	// encap pushes data 4 bits later; decap pulls it 4 bits earlier
	always_comb
	begin
		if (enc_i)
		begin
			byte_o  = {carry_i, cur_i[7:4]};
			carry_o = cur_i[3:0];
		end
		else
		begin
			byte_o  = {carry_i, cur_i[7:4]};
			carry_o = cur_i[3:0];
		end
	end
endmodule

// [hw/rcf_framer.sv]
`timescale 1ns/1ps
module rcf_framer
	import rcf_pkg::*;
#(
	parameter int HFN_W = 25
)(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	// job start
	input  wire logic             job_start_i,
	input  wire logic             job_encap_i,
	input  wire logic [1:0]       cipher_sel_i,
	input  wire logic             hfn_auto_inc_i,
	input  wire logic [31:0]      pdb_word0_i,
	input  wire logic [31:0]      pdb_word1_i,
	input  wire logic [31:0]      pdb_bearer_dir_i,
	input  wire logic [HFN_W-1:0] pdb_thresh_i,
	// override register write
	input  wire logic             ovr_wr_i,
	input  wire logic [31:0]      ovr_wdata_i,
	// input frame byte stream
	input  wire logic             in_valid_i,
	input  wire logic [7:0]       in_byte_i,
	input  wire logic             in_last_i,
	output logic                  in_ready_o,
	// cipher unit
	output logic                  iv_load_o,
	output logic      [63:0]      iv_o,
	output logic      [1:0]       cipher_alg_o,
	output logic                  ciph_valid_o,
	output logic      [7:0]       ciph_byte_o,
	output logic                  ciph_last_o,
	input  wire logic             ciph_ready_i,
	input  wire logic             ciph_res_valid_i,
	input  wire logic [7:0]       ciph_res_byte_i,
	input  wire logic             ciph_res_last_i,
	// output frame byte stream
	output logic                  out_valid_o,
	output logic      [7:0]       out_byte_o,
	output logic                  out_last_o,
	// data block write back and status
	output logic                  pdb_wb_o,
	output logic      [31:0]      pdb_wb_word1_o,
	output logic      [31:0]      ovr_rdata_o,
	output logic                  done_o,
	output logic      [1:0]       status_o,
	output logic                  busy_o
);
	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_HDR  = 7'h02,
		ST_IV   = 7'h04,
		ST_PAY  = 7'h08,
		ST_DRN  = 7'h10,
		ST_TAIL = 7'h20,
		ST_FIN  = 7'h40
	} rcf_state_e;

	if (HFN_W != HFN_W20 && HFN_W != HFN_W25)
	begin : g_bad_width
		$error("hfn width must be 20 or 25");
	end

	rcf_state_e       state_r;
	logic [31:0]      ovr_r;
	logic             enc_r;
	logic             um7_r;
	logic             shift_r;
	logic             inc_en_r;
	logic [HFN_W-1:0] hfn_r;
	logic [11:0]      last_sn_r;
	logic             last_vld_r;
	logic [15:0]      hdr_r;
	logic [1:0]       hdr_cnt_r;
	logic [3:0]       carry_r;
	logic             first_r;
	logic             in_done_r;
	logic [7:0]       out_src_byte;
	logic [1:0]       sns_code;
	logic             opt_bad;
	logic [HFN_W-1:0] hfn_sel;
	logic [11:0]      sn;
	logic             wrap;
	logic [HFN_W-1:0] hfn_next;
	logic             rekey;
	logic [7:0]       al_byte;
	logic [3:0]       al_carry;
	logic             in_take;
	logic [1:0]       hdr_len;

	// encap reads 2-bit code, decap only bit 1
	assign sns_code = job_encap_i ? pdb_word0_i[OPT_SNS_LO+1:OPT_SNS_LO] : {1'b0, pdb_word0_i[OPT_SNS_LO]};
	assign opt_bad  = (sns_code == SNS_RSVD) || (!job_encap_i && sns_code == SNS_LEN15);
	// override flag replaces stored count
	assign hfn_sel  = ovr_r[OVR_FLAG_BIT] ? ovr_r[HFN_W-1:0] : pdb_word1_i[31:32-HFN_W];
	assign hdr_len  = um7_r ? 2'h1 : 2'h2;

	rcf_seq_track #(
		.HFN_W(HFN_W)
	) u_seq (
		.um7_i      (um7_r),
		.hdr_i      (hdr_r),
		.hfn_i      (hfn_r),
		.thresh_i   (pdb_thresh_i),
		.last_sn_i  (last_sn_r),
		.last_vld_i (last_vld_r),
		.sn_o       (sn),
		.wrap_o     (wrap),
		.hfn_next_o (hfn_next),
		.rekey_o    (rekey)
	);

	rcf_nibble_align u_align (
		.cur_i   ((enc_r && state_r != ST_HDR) ? ciph_res_byte_i : in_byte_i),
		.carry_i (carry_r),
		.enc_i   (enc_r),
		.byte_o  (al_byte),
		.carry_o (al_carry)
	);

	assign in_take = in_valid_i && in_ready_o;

	// override register, software visible
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			ovr_r <= OVR_RESET;
		else if (ovr_wr_i)
			ovr_r <= ovr_wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			ovr_rdata_o <= OVR_RESET;
		else
			ovr_rdata_o <= ovr_r;
	end

	// main sequence
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state_r   <= ST_IDLE;
			enc_r     <= 1'b0;
			um7_r     <= 1'b0;
			shift_r   <= 1'b0;
			inc_en_r  <= 1'b0;
			hfn_r     <= '0;
			hdr_r     <= 16'h0000;
			hdr_cnt_r <= 2'h0;
			in_done_r <= 1'b0;
			done_o    <= 1'b0;
			status_o  <= ST_OK;
			busy_o    <= 1'b0;
			iv_load_o <= 1'b0;
			iv_o      <= 64'h0;
			cipher_alg_o <= ALG_NULL;
			pdb_wb_o  <= 1'b0;
			pdb_wb_word1_o <= 32'h0;
			last_sn_r <= 12'h000;
			last_vld_r <= 1'b0;
		end
		else
		begin
			done_o    <= 1'b0;
			iv_load_o <= 1'b0;
			pdb_wb_o  <= 1'b0;
			unique case (state_r)
				ST_IDLE:
				begin
					if (job_start_i)
					begin
						if (opt_bad)
						begin
							done_o   <= 1'b1;
							status_o <= ST_BADOPT;
						end
						else
						begin
							state_r  <= ST_HDR;
							busy_o   <= 1'b1;
							enc_r    <= job_encap_i;
							um7_r    <= (sns_code == SNS_UM7);
							shift_r  <= pdb_word0_i[OPT_SHIFT_BIT];
							inc_en_r <= !job_encap_i || hfn_auto_inc_i;
							hfn_r    <= hfn_sel;
							cipher_alg_o <= cipher_sel_i;
							hdr_cnt_r <= 2'h0;
							in_done_r <= 1'b0;
						end
					end
				end
				ST_HDR:
				begin
					// decap shift: first byte only primes the carry
					if (in_take && !(shift_r && !enc_r && first_r))
					begin
						// header gathered for iv, never to cipher
						hdr_r     <= (hdr_cnt_r == 2'h0) ? {out_src_byte, 8'h00} : {hdr_r[15:8], out_src_byte};
						hdr_cnt_r <= hdr_cnt_r + 2'h1;
						in_done_r <= in_last_i;
						if (hdr_cnt_r + 2'h1 == hdr_len)
							state_r <= ST_IV;
					end
				end
				ST_IV:
				begin
					// iv goes to class 1 context ahead of payload
					iv_load_o <= 1'b1;
					iv_o      <= {hfn_next, sn, (52-HFN_W)'(0)} | {32'h0, pdb_bearer_dir_i};
					if (inc_en_r)
						hfn_r <= hfn_next;
					if (inc_en_r && wrap)
					begin
						pdb_wb_o       <= 1'b1;
						pdb_wb_word1_o <= {hfn_next, (32-HFN_W)'(0)};
					end
					last_sn_r  <= sn;
					last_vld_r <= 1'b1;
					status_o   <= rekey ? ST_REKEY : ST_OK;
					state_r    <= in_done_r ? ST_DRN : ST_PAY;
				end
				ST_PAY:
				begin
					if (in_take && in_last_i)
						state_r <= ST_DRN;
				end
				ST_DRN:
				begin
					if (in_done_r || (ciph_res_valid_i && ciph_res_last_i))
						state_r <= (shift_r ? ST_TAIL : ST_FIN);
				end
				ST_TAIL:
					state_r <= ST_FIN;
				ST_FIN:
				begin
					done_o  <= 1'b1;
					busy_o  <= 1'b0;
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// raw input byte for header and payload, realigned on decap shift
	assign out_src_byte = (shift_r && !enc_r) ? al_byte : in_byte_i;

	// carry nibble: lead nibble primes encap shift
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			carry_r <= 4'h0;
			first_r <= 1'b1;
		end
		else if (state_r == ST_IDLE)
		begin
			carry_r <= pdb_word0_i[LEAD_LO+3:LEAD_LO];
			first_r <= 1'b1;
		end
		else if (in_take && (!enc_r || state_r == ST_HDR))
		begin
			carry_r <= (enc_r || !first_r) ? al_carry : in_byte_i[3:0];
			first_r <= 1'b0;
		end
		else if (enc_r && ciph_res_valid_i)
			carry_r <= al_carry;
	end

	// payload to input fifo as message data
	// byte held until the cipher takes it, so a stall never drops one
	assign in_ready_o = (state_r == ST_HDR) || (state_r == ST_PAY && (!ciph_valid_o || ciph_ready_i));
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ciph_valid_o <= 1'b0;
			ciph_byte_o  <= 8'h00;
			ciph_last_o  <= 1'b0;
		end
		else if (state_r == ST_PAY && in_take)
		begin
			ciph_valid_o <= 1'b1;
			ciph_byte_o  <= out_src_byte;
			ciph_last_o  <= in_last_i;
		end
		else if (ciph_ready_i)
		begin
			ciph_valid_o <= 1'b0;
			ciph_last_o  <= 1'b0;
		end
	end

	// output: header, realigned on shift, then ciphered payload, then tail on encap shift
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			out_valid_o <= 1'b0;
			out_byte_o  <= 8'h00;
			out_last_o  <= 1'b0;
		end
		else if (state_r == ST_HDR && in_take && !(shift_r && !enc_r && first_r))
		begin
			out_valid_o <= 1'b1;
			out_byte_o  <= (shift_r && enc_r) ? al_byte : out_src_byte;
			out_last_o  <= in_last_i && !(shift_r && enc_r);
		end
		else if (ciph_res_valid_i && state_r != ST_IDLE)
		begin
			out_valid_o <= 1'b1;
			out_byte_o  <= (shift_r && enc_r) ? al_byte : ciph_res_byte_i;
			out_last_o  <= ciph_res_last_i && !(shift_r && enc_r);
		end
		else if (state_r == ST_TAIL && enc_r)
		begin
			// trailing zero nibble pads the extra byte
			out_valid_o <= 1'b1;
			out_byte_o  <= {carry_r, 4'h0};
			out_last_o  <= 1'b1;
		end
		else
		begin
			out_valid_o <= 1'b0;
			out_last_o  <= 1'b0;
		end
	end
	// limitation: in-order flows assumed, no count roll back
	// ring jobs fill override via immediate load beforehand
endmodule

// [verification/rcf_framer_sva.sv]
`timescale 1ns/1ps
module rcf_framer_chk
	import rcf_pkg::*;
#(
	parameter int HFN_W = 25
)(
	// watched ports
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        job_start_i,
	input  wire logic        job_encap_i,
	input  wire logic [31:0] pdb_word0_i,
	input  wire logic        ovr_wr_i,
	input  wire logic [31:0] ovr_wdata_i,
	input  wire logic        ciph_ready_i,
	input  wire logic        iv_load_o,
	input  wire logic        ciph_valid_o,
	input  wire logic [7:0]  ciph_byte_o,
	input  wire logic        pdb_wb_o,
	input  wire logic [31:0] ovr_rdata_o,
	input  wire logic        done_o,
	input  wire logic [1:0]  status_o,
	input  wire logic        busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic iv_seen_r;
	// cleared at completion so each job needs its own iv
	always_ff @(posedge clk_i)
		if (sys_rst_i || done_o)
			iv_seen_r <= 1'b0;
		else if (iv_load_o)
			iv_seen_r <= 1'b1;
	sequence s_bad;
		job_start_i && !busy_o && job_encap_i && pdb_word0_i[2:1] == SNS_RSVD;
	endsequence
	sequence s_wr;
		ovr_wr_i ##1 !ovr_wr_i;
	endsequence
	AST_BADOPT: assert property (s_bad |=> done_o && status_o == ST_BADOPT)
		else $error("reserved size code not refused");
	AST_OVR_RST: assert property ($past(sys_rst_i) |-> ovr_rdata_o == OVR_RESET)
		else $error("override not zero after reset");
	AST_OVR_RB: assert property (s_wr |=> ovr_rdata_o == $past(ovr_wdata_i, 2))
		else $error("override readback wrong");
	AST_IV_FIRST: assert property (ciph_valid_o |-> iv_seen_r || iv_load_o)
		else $error("payload before iv load");
	AST_IV_PULSE: assert property (iv_load_o |=> !iv_load_o)
		else $error("iv load longer than one cycle");
	AST_DONE_PULSE: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	AST_WB_IV: assert property (pdb_wb_o |-> iv_load_o)
		else $error("write back outside iv cycle");
	AST_CIPH_HOLD: assert property (ciph_valid_o && !ciph_ready_i |=> ciph_valid_o && $stable(ciph_byte_o))
		else $error("payload byte dropped while stalled");
endmodule
bind rcf_framer rcf_framer_chk #(.HFN_W(HFN_W)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.job_start_i(job_start_i), .job_encap_i(job_encap_i), .pdb_word0_i(pdb_word0_i), .ovr_wr_i(ovr_wr_i),
	.ovr_wdata_i(ovr_wdata_i), .ciph_ready_i(ciph_ready_i), .iv_load_o(iv_load_o), .ciph_valid_o(ciph_valid_o),
	.ciph_byte_o(ciph_byte_o), .pdb_wb_o(pdb_wb_o), .ovr_rdata_o(ovr_rdata_o), .done_o(done_o),
	.status_o(status_o), .busy_o(busy_o));

// [verification/rcf_cipher_model.sv]
`timescale 1ns/1ps
module rcf_cipher_model
	import rcf_pkg::*;
(
	// control
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       slow_i,
	input  wire logic [1:0] alg_i,
	// payload in and result out
	input  wire logic       valid_i,
	input  wire logic [7:0] byte_i,
	input  wire logic       last_i,
	output logic            ready_o,
	output logic            res_valid_o,
	output logic      [7:0] res_byte_o,
	output logic            res_last_o
);
	logic [1:0] tick_r;
	// slow mode accepts two cycles of four
	assign ready_o = !slow_i || tick_r[1];
	always_ff @(posedge clk_i)
	begin
		tick_r <= sys_rst_i ? 2'h0 : tick_r + 2'h1;
		res_valid_o <= !sys_rst_i && valid_i && ready_o;
		res_last_o <= !sys_rst_i && valid_i && ready_o && last_i;
		if (sys_rst_i)
			res_byte_o <= 8'h00;
		else if (valid_i && ready_o)
			res_byte_o <= byte_i ^ ((alg_i == ALG_NULL) ? 8'h00 : 8'h5A);
		else
			res_byte_o <= ~res_byte_o; // stale data must not look valid
	end
endmodule

// [verification/rcf_framer_test.sv]
`timescale 1ns/1ps
module rcf_framer_test;
	import rcf_pkg::*;
	logic        clk_i, sys_rst_i, job_start_i, job_encap_i, hfn_auto_inc_i, ovr_wr_i, in_valid_i, in_last_i;
	logic        in_ready_o, iv_load_o, ciph_valid_o, ciph_last_o, cready, rvalid, rlast, slow, wb_seen;
	logic        out_valid_o, out_last_o, pdb_wb_o, done_o, busy_o;
	logic [1:0]  cipher_sel_i, status_o, cipher_alg_o;
	logic [7:0]  in_byte_i, ciph_byte_o, rbyte, out_byte_o;
	logic [24:0] thresh;
	logic [31:0] pdb_word0_i, pdb_word1_i, ovr_wdata_i, ovr_rdata_o, pdb_wb_word1_o, wb_val;
	logic [63:0] iv_o, iv_val;
	logic [7:0]  inq[$], outq[$], expq[$];
	int          fail_count, comparisons, ivs, last_at;
	rcf_framer #(.HFN_W(25)) dut (.clk_i, .sys_rst_i, .job_start_i, .job_encap_i, .cipher_sel_i, .hfn_auto_inc_i,
		.pdb_word0_i, .pdb_word1_i, .pdb_bearer_dir_i(32'h0000_0A40), .pdb_thresh_i(thresh), .ovr_wr_i,
		.ovr_wdata_i, .in_valid_i, .in_byte_i, .in_last_i, .in_ready_o, .iv_load_o, .iv_o, .cipher_alg_o,
		.ciph_valid_o, .ciph_byte_o, .ciph_last_o, .ciph_ready_i(cready), .ciph_res_valid_i(rvalid),
		.ciph_res_byte_i(rbyte), .ciph_res_last_i(rlast), .out_valid_o, .out_byte_o, .out_last_o, .pdb_wb_o,
		.pdb_wb_word1_o, .ovr_rdata_o, .done_o, .status_o, .busy_o);
	rcf_cipher_model u_ciph (.clk_i, .sys_rst_i, .slow_i(slow), .alg_i(cipher_alg_o), .valid_i(ciph_valid_o),
		.byte_i(ciph_byte_o), .last_i(ciph_last_o), .ready_o(cready), .res_valid_o(rvalid),
		.res_byte_o(rbyte), .res_last_o(rlast));
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		if (out_valid_o)
			outq.push_back(out_byte_o);
		if (out_valid_o && out_last_o)
			last_at = outq.size();
		if (iv_load_o)
		begin
			ivs++;
			iv_val = iv_o;
		end
		if (pdb_wb_o)
		begin
			wb_seen = 1'b1;
			wb_val = pdb_wb_word1_o;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmpq();
		chk(outq.size(), expq.size());
		chk(last_at, expq.size());
		foreach (expq[i])
			chk(outq[i], expq[i]);
	endtask
	task automatic job(input logic enc, input logic [1:0] alg, input logic [7:0] opt, input logic [31:0] w1);
		int i;
		int n;
		i = 0;
		n = 0;
		outq = {};
		ivs = 0;
		last_at = 0;
		wb_seen = 1'b0;
		@(posedge clk_i);
		job_start_i <= 1'b1;
		job_encap_i <= enc;
		cipher_sel_i <= alg;
		pdb_word0_i <= {4'h0, 4'h9, 16'h0000, opt};
		pdb_word1_i <= w1;
		@(posedge clk_i);
		job_start_i <= 1'b0;
		while (i < inq.size() && n < 300)
		begin
			in_valid_i <= 1'b1;
			in_byte_i <= inq[i];
			in_last_i <= (i == inq.size() - 1);
			@(posedge clk_i);
			n++;
			if (in_ready_o)
				i++;
		end
		in_valid_i <= 1'b0;
		while (done_o !== 1'b1 && n < 600)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 600)
		begin
			fail_count++;
			close_out();
		end
		repeat (2) @(posedge clk_i);
	endtask
	task automatic ovr_write(input logic [31:0] v);
		@(posedge clk_i);
		ovr_wr_i <= 1'b1;
		ovr_wdata_i <= v;
		@(posedge clk_i);
		ovr_wr_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic t_reg();
		chk(ovr_rdata_o, OVR_RESET);
		ovr_write(32'h81AB_CDEF);
		chk(ovr_rdata_o, 32'h81AB_CDEF);
		$display("t_reg done");
	endtask
	task automatic t_wrap();
		hfn_auto_inc_i <= 1'b0;
		inq = {8'hFE, 8'h11};
		job(1'b0, ALG_SNOW, 8'h02, 32'h0000_0080);
		inq = {8'h00, 8'h22};
		job(1'b0, ALG_SNOW, 8'h02, 32'h0000_0080);
		chk(wb_seen, 1'b1);
		chk(wb_val, {25'h1ABC_DF0, 7'h00});
		chk(status_o, ST_OK);
		expq = {8'h00, 8'h78};
		cmpq();
		ovr_write(32'h0000_0000);
		$display("t_wrap done");
	endtask
	task automatic t_am12();
		logic [63:0] iv_exp;
		iv_exp = {25'h010, 12'h246, 27'h000_0A40};
		hfn_auto_inc_i <= 1'b1;
		slow <= 1'b1;
		thresh <= 25'h10;
		inq = {8'h12, 8'h34, 8'hA0, 8'hB1, 8'hC2};
		job(1'b1, ALG_KASUMI, 8'h00, {25'h10, 7'h00});
		expq = {8'h12, 8'h34, 8'hFA, 8'hEB, 8'h98};
		cmpq();
		chk(ivs, 1);
		chk(iv_val[63:32], iv_exp[63:32]);
		chk(iv_val[31:0], iv_exp[31:0]);
		chk(status_o, ST_REKEY);
		slow <= 1'b0;
		$display("t_am12 done");
	endtask
	task automatic t_shift();
		inq = {8'hAB, 8'hCD, 8'hEF};
		job(1'b1, ALG_NULL, 8'h03, 32'h0000_0000);
		expq = {8'h9A, 8'hBC, 8'hDE, 8'hF0};
		cmpq();
		chk(status_o, ST_OK);
		$display("t_shift done");
	endtask
	task automatic t_dshift();
		inq = {8'h91, 8'h23, 8'h45, 8'h60};
		job(1'b0, ALG_SNOW, 8'h01, 32'h0000_0000);
		expq = {8'h12, 8'h34, 8'h0C};
		cmpq();
		chk(status_o, ST_OK);
		$display("t_dshift done");
	endtask
	task automatic t_bad();
		inq = {};
		job(1'b1, ALG_KASUMI, 8'h06, 32'h0000_0000);
		chk(status_o, ST_BADOPT);
		chk(outq.size(), 0);
		$display("t_bad done");
	endtask
	initial
	begin
		sys_rst_i = 1'b1;
		{job_start_i, job_encap_i, hfn_auto_inc_i, ovr_wr_i, in_valid_i, in_last_i, slow} = '0;
		{cipher_sel_i, in_byte_i, pdb_word0_i, pdb_word1_i, ovr_wdata_i} = '0;
		thresh = '1;
		fail_count = 0;
		comparisons = 0;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		t_reg();
		t_wrap();
		t_am12();
		t_shift();
		t_dshift();
		t_bad();
		close_out();
	end
endmodule
